// ### rtl/ssx_addr_gen.sv
// file register address resolution for byte-oriented instructions
`timescale 1ns/1ps
`include "ssx_regs.svh"
module ssx_addr_gen (
	// operand
	input wire logic [7:0] file_addr_i,
	input wire logic access_bit_i,
	// bank and index state
	input wire logic [3:0] bank_select_reg_i,
	input wire logic [11:0] index_base_i,
	input wire logic ext_set_en_i,
	// resolved address
	output logic [11:0] full_addr_o,
	output logic indexed_o
);
	wire use_indexed;
	wire access_low;
	wire [11:0] access_addr;
	wire [11:0] banked_addr;
	wire [11:0] indexed_addr;
	// indexed literal offset only below the split
	assign use_indexed = ext_set_en_i && !access_bit_i
		&& (file_addr_i <= `SSX_ILO_MAX);
	// access bank: offsets below 60h map to bank 0, the rest to the top bank
	assign access_low = file_addr_i < `SSX_ACCESS_SPLIT;
	assign access_addr = access_low ? {4'h0, file_addr_i}
		: {`SSX_ACCESS_HI_BANK, file_addr_i};
	assign banked_addr = {bank_select_reg_i, file_addr_i};
	assign indexed_addr = index_base_i + {4'h0, file_addr_i};
	assign full_addr_o = use_indexed ? indexed_addr
		: (access_bit_i ? banked_addr : access_addr);
	assign indexed_o = use_indexed;
endmodule // ssx_addr_gen

// ### rtl/ssx_exec.sv
// execution of set-all-ones, sleep and subtract-with-borrow instructions
// Behaviour
// - set-all-ones writes FFh, flags untouched
// - access bit 0 uses access bank
// - access bit 1 uses bank select register
// - extended set, access bit 0, offsets up to 5Fh use indexed addressing
// - sleep clears power-down flag
// - sleep sets time-out flag
// - sleep clears watchdog and postscaler
// - after sleep, halt until wake-up
// - watchdog wake-up clears time-out flag
`timescale 1ns/1ps
`include "ssx_regs.svh"
module ssx_exec (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// instruction and configuration
	input wire logic [15:0] instr_i,
	input wire logic instr_valid_i,
	input wire logic ext_set_en_i,
	input wire logic [3:0] bank_select_reg_i,
	input wire logic [11:0] index_base_i,
	// working register and data memory
	input wire logic [7:0] w_reg_i,
	input wire logic [7:0] file_rdata_i,
	// wake-up sources, asynchronous pins
	input wire logic wdt_timeout_i,
	input wire logic ext_wake_i,
	// data memory access
	output logic [11:0] file_addr_o,
	output logic [7:0] file_wdata_o,
	output logic file_we_o,
	output logic [7:0] w_wdata_o,
	output logic w_we_o,
	// status
	output logic [4:0] alu_flags_o,
	output logic flags_we_o,
	output logic power_down_flag_o,
	output logic time_out_flag_o,
	output logic wdt_clear_o,
	output logic osc_run_o,
	output logic [1:0] phase_o
);
	ssx_pkg::ssx_phase_e phase;
	ssx_pkg::ssx_phase_e next_phase;
	ssx_pkg::ssx_state_e state;
	logic [15:0] ir;
	logic [7:0] operand;
	logic [8:0] result;
	logic [4:0] flags;
	logic wdt_meta, wdt_sync, ext_meta, ext_sync;

	wire [11:0] addr_res;
	wire is_set;
	wire is_sub;
	wire is_sleep;
	wire dest_file;
	wire [8:0] diff;
	wire [4:0] diff_lo;
	wire ovf;
	wire asleep;
	wire wake;
	wire [15:0] fetch_word;
	wire [15:0] addr_src;

	// subtract as w + ~f + carry, so carry out is the no-borrow flag
	function automatic logic [8:0] sub_borrow(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		sub_borrow = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
	endfunction

	// decode
	assign is_set = ir[15:9] == `SSX_OP_SET_HI;
	assign is_sub = ir[15:10] == `SSX_OP_SUB_HI;
	assign is_sleep = ir == `SSX_OP_SLEEP;
	assign dest_file = ir[9];
	assign diff = sub_borrow(w_reg_i, operand, flags[`SSX_FLAG_C]);
	assign diff_lo = {1'b0, w_reg_i[3:0]} + {1'b0, ~operand[3:0]}
		+ {4'h0, flags[`SSX_FLAG_C]};
	assign ovf = (w_reg_i[7] != operand[7]) && (diff[7] != w_reg_i[7]);
	assign asleep = state == ssx_pkg::SSX_SLEEP;
	assign wake = wdt_sync || ext_sync;
	// an idle slot decodes as a no-operation word
	assign fetch_word = instr_valid_i ? instr_i : 16'h0000;
	// resolve from the incoming word in Q1, so the read in Q2
	// already sees the new operand's address, not the last one
	assign addr_src = (phase == ssx_pkg::SSX_Q1 && !asleep) ? fetch_word
		: ir;
	// phases advance only while awake; sleep freezes at Q1
	assign next_phase = asleep ? ssx_pkg::SSX_Q1
		: ssx_pkg::ssx_phase_e'(phase + 2'b01);

	ssx_addr_gen u_addr (
		.file_addr_i(addr_src[7:0]),
		.access_bit_i(addr_src[8]),
		.bank_select_reg_i(bank_select_reg_i),
		.index_base_i(index_base_i),
		.ext_set_en_i(ext_set_en_i),
		.full_addr_o(addr_res),
		.indexed_o()
	);

	// two-flop synchronisers for the wake pins
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wdt_meta <= 1'b0;
			wdt_sync <= 1'b0;
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			wdt_meta <= wdt_timeout_i;
			wdt_sync <= wdt_meta;
			ext_meta <= ext_wake_i;
			ext_sync <= ext_meta;
		end
	end

	// phase counter
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			phase <= ssx_pkg::SSX_Q1;
		else
			phase <= next_phase;
	end

	// Q1 decode latch, Q2 operand read
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ir <= 16'h0000;
			operand <= 8'h00;
		end else if (!asleep) begin
			if (phase == ssx_pkg::SSX_Q1) begin
				ir <= fetch_word;
			end
			if (phase == ssx_pkg::SSX_Q2) begin
				operand <= file_rdata_i;
			end
		end
	end

	// Q3 process
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			result <= 9'h000;
		else if (!asleep && phase == ssx_pkg::SSX_Q3)
			result <= is_set ? {1'b0, `SSX_ALL_ONES} : diff;
	end

	// Q4 write-back strobes, one cycle wide
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			file_we_o <= 1'b0;
			w_we_o <= 1'b0;
			flags_we_o <= 1'b0;
			file_wdata_o <= 8'h00;
			w_wdata_o <= 8'h00;
			file_addr_o <= 12'h000;
		end else begin
			file_addr_o <= addr_res;
			file_wdata_o <= result[7:0];
			w_wdata_o <= result[7:0];
			file_we_o <= !asleep && phase == ssx_pkg::SSX_Q4
				&& (is_set || (is_sub && dest_file));
			w_we_o <= !asleep && phase == ssx_pkg::SSX_Q4
				&& is_sub && !dest_file;
			// set-all-ones leaves every flag alone
			flags_we_o <= !asleep && phase == ssx_pkg::SSX_Q4 && is_sub;
		end
	end

	// arithmetic flags computed in Q3
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			flags <= 5'h00;
		else if (!asleep && phase == ssx_pkg::SSX_Q3 && is_sub) begin
			flags[`SSX_FLAG_N] <= diff[7];
			flags[`SSX_FLAG_OV] <= ovf;
			flags[`SSX_FLAG_Z] <= diff[7:0] == 8'h00;
			flags[`SSX_FLAG_DC] <= diff_lo[4];
			flags[`SSX_FLAG_C] <= diff[8];
		end
	end

	// sleep entry at Q4, wake on a synchronised event
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ssx_pkg::SSX_RUN;
			power_down_flag_o <= `SSX_PD_RESET;
			time_out_flag_o <= `SSX_TO_RESET;
			wdt_clear_o <= 1'b0;
			osc_run_o <= 1'b1;
		end else begin
			wdt_clear_o <= 1'b0;
			case (state)
			ssx_pkg::SSX_RUN: begin
				if (phase == ssx_pkg::SSX_Q4 && is_sleep) begin
					power_down_flag_o <= 1'b0;
					time_out_flag_o <= 1'b1;
					wdt_clear_o <= 1'b1;
					osc_run_o <= 1'b0;
					state <= ssx_pkg::SSX_SLEEP;
				end
			end
			ssx_pkg::SSX_SLEEP: begin
				// wake pins are watched on this clock, already synchronised
				if (wake) begin
					state <= ssx_pkg::SSX_RUN;
					osc_run_o <= 1'b1;
					if (wdt_sync)
						time_out_flag_o <= 1'b0;
				end
			end
			default: state <= ssx_pkg::SSX_RUN;
			endcase
		end
	end

	assign alu_flags_o = flags;
	assign phase_o = phase;
endmodule // ssx_exec

// ### rtl/ssx_pkg.sv
// types for the set, sleep and subtract-with-borrow execution block
package ssx_pkg;
	typedef enum logic [1:0] {
		SSX_Q1 = 2'b00,
		SSX_Q2 = 2'b01,
		SSX_Q3 = 2'b10,
		SSX_Q4 = 2'b11
	} ssx_phase_e;
	typedef enum logic [1:0] {
		SSX_RUN = 2'b00,
		SSX_SLEEP = 2'b01
	} ssx_state_e;
endpackage

// ### rtl/ssx_regs.svh
// constants for the set, sleep and subtract-with-borrow execution block
`ifndef SSX_REGS_SVH
`define SSX_REGS_SVH
`define SSX_OP_SET_HI 7'h34
`define SSX_OP_SUB_HI 6'h15
`define SSX_OP_SLEEP 16'h0003
`define SSX_ALL_ONES 8'hFF
`define SSX_ILO_MAX 8'h5F
`define SSX_ACCESS_SPLIT 8'h60
`define SSX_ACCESS_HI_BANK 4'hF
`define SSX_FLAG_N 4
`define SSX_FLAG_OV 3
`define SSX_FLAG_Z 2
`define SSX_FLAG_DC 1
`define SSX_FLAG_C 0
`define SSX_PD_RESET 1'b1
`define SSX_TO_RESET 1'b1
`endif

// ### verification/ssx_exec_checker.sv
// concurrent checks on the execution block ports
`timescale 1ns/1ps
module ssx_exec_checker (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// watched signals
	input wire logic wdt_timeout_i,
	input wire logic [7:0] file_wdata_o,
	input wire logic file_we_o,
	input wire logic w_we_o,
	input wire logic [4:0] alu_flags_o,
	input wire logic flags_we_o,
	input wire logic power_down_flag_o,
	input wire logic time_out_flag_o,
	input wire logic wdt_clear_o,
	input wire logic osc_run_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// only the set instruction writes a file register without flags
	property p_set_ones;
		file_we_o && !flags_we_o |-> file_wdata_o == 8'hFF;
	endproperty
	a_set_ones: assert property (p_set_ones) else $error("set wrote not ones");
	// flags settle in Q3, one cycle ahead of their write strobe
	property p_flag_chg;
		$changed(alu_flags_o) |=> flags_we_o;
	endproperty
	a_flag_chg: assert property (p_flag_chg) else $error("flags moved alone");
	// the oscillator stops on the same edge as the status updates
	property p_sleep_pd;
		$fell(osc_run_o) |-> !power_down_flag_o;
	endproperty
	a_sleep_pd: assert property (p_sleep_pd) else $error("pd not cleared");
	property p_sleep_to;
		$fell(osc_run_o) |-> time_out_flag_o;
	endproperty
	a_sleep_to: assert property (p_sleep_to) else $error("to not set");
	property p_wdt_clr;
		$fell(osc_run_o) |-> wdt_clear_o ##1 !wdt_clear_o;
	endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("wdt not cleared");
	property p_halt;
		!osc_run_o |-> !(file_we_o || w_we_o || flags_we_o);
	endproperty
	a_halt: assert property (p_halt) else $error("write while asleep");
	property p_wdt_wake;
		$rose(osc_run_o) && wdt_timeout_i |-> !time_out_flag_o;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("to kept on wake");
	property p_we_pulse;
		file_we_o |=> !file_we_o [*3];
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write too long");
	c_set: cover property (file_we_o && !flags_we_o);
	c_sub: cover property (flags_we_o && w_we_o);
	c_wake: cover property ($rose(osc_run_o));
endmodule // ssx_exec_checker
bind ssx_exec ssx_exec_checker u_chk (
	.ref_clk_i(ref_clk_i),
	.arst_n_i(arst_n_i),
	.wdt_timeout_i(wdt_timeout_i),
	.file_wdata_o(file_wdata_o),
	.file_we_o(file_we_o),
	.w_we_o(w_we_o),
	.alu_flags_o(alu_flags_o),
	.flags_we_o(flags_we_o),
	.power_down_flag_o(power_down_flag_o),
	.time_out_flag_o(time_out_flag_o),
	.wdt_clear_o(wdt_clear_o),
	.osc_run_o(osc_run_o)
);

// ### verification/tb_ssx_exec.sv
// directed bench for the execution block
`timescale 1ns/1ps
module tb_ssx_exec;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [15:0] instr_i = 16'h0000;
	logic instr_valid_i = 1'b0;
	logic ext_set_en_i = 1'b0;
	logic [3:0] bank_select_reg_i = 4'h5;
	logic [11:0] index_base_i = 12'h100;
	logic [7:0] w_reg_i = 8'h02;
	logic [7:0] file_rdata_i = 8'h03;
	logic wdt_timeout_i = 1'b0;
	logic ext_wake_i = 1'b0;
	logic [11:0] file_addr_o;
	logic [7:0] file_wdata_o, w_wdata_o;
	logic [4:0] alu_flags_o;
	logic [1:0] phase_o;
	logic file_we_o, w_we_o, flags_we_o, wdt_clear_o, osc_run_o;
	logic power_down_flag_o, time_out_flag_o;
	int miscompares = 0;
	int samples_checked = 0;
	ssx_exec DUT (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.instr_i(instr_i),
		.instr_valid_i(instr_valid_i),
		.ext_set_en_i(ext_set_en_i),
		.bank_select_reg_i(bank_select_reg_i),
		.index_base_i(index_base_i),
		.w_reg_i(w_reg_i),
		.file_rdata_i(file_rdata_i),
		.wdt_timeout_i(wdt_timeout_i),
		.ext_wake_i(ext_wake_i),
		.file_addr_o(file_addr_o),
		.file_wdata_o(file_wdata_o),
		.file_we_o(file_we_o),
		.w_wdata_o(w_wdata_o),
		.w_we_o(w_we_o),
		.alu_flags_o(alu_flags_o),
		.flags_we_o(flags_we_o),
		.power_down_flag_o(power_down_flag_o),
		.time_out_flag_o(time_out_flag_o),
		.wdt_clear_o(wdt_clear_o),
		.osc_run_o(osc_run_o),
		.phase_o(phase_o)
	);
	always #2.5 ref_clk_i = ~ref_clk_i;
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// waits are bounded so a dead design cannot hang the run
	task automatic run(input logic [15:0] op);
		int n;
		n = 0;
		@(negedge ref_clk_i);
		while (phase_o !== 2'h0 && n < 8) begin
			@(negedge ref_clk_i);
			n++;
		end
		instr_i = op;
		instr_valid_i = 1'b1;
		@(negedge ref_clk_i);
		instr_valid_i = 1'b0;
		n = 0;
		while (!(file_we_o === 1'b1 || w_we_o === 1'b1) && n < 6) begin
			@(negedge ref_clk_i);
			n++;
		end
	endtask
	task automatic set_at(input logic ext, input logic a,
		input logic [7:0] f, input logic [11:0] exp);
		ext_set_en_i = ext;
		run({7'h34, a, f});
		check("file_addr_o", file_addr_o, exp);
		check("file_wdata_o", file_wdata_o, 8'hFF);
		check("file_we_o", file_we_o, 1'b1);
		check("flags_we_o", flags_we_o, 1'b0);
	endtask
	task automatic wake();
		int n;
		n = 0;
		while (osc_run_o !== 1'b1 && n < 10) begin
			@(negedge ref_clk_i);
			n++;
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog, far beyond the roughly 110 cycles the tests need
	initial begin
		#5000;
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (3) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		check("pd_rst", power_down_flag_o, 1'b1);
		check("osc_rst", osc_run_o, 1'b1);
		set_at(1'b0, 1'b0, 8'h20, 12'h020);
		set_at(1'b0, 1'b0, 8'h80, 12'hF80);
		set_at(1'b0, 1'b1, 8'h12, 12'h512);
		set_at(1'b1, 1'b0, 8'h5F, 12'h15F);
		set_at(1'b1, 1'b0, 8'h60, 12'hF60);
		set_at(1'b1, 1'b1, 8'h12, 12'h512);
		// carry starts clear, so the borrow is taken and 2 - 3 - 1 gives FE
		run({6'h15, 1'b1, 1'b1, 8'h10});
		check("sub_f", file_wdata_o, 8'hFE);
		check("flags1", alu_flags_o, 5'h10);
		check("sub_fwe", flags_we_o, 1'b1);
		w_reg_i = 8'h05;
		run({6'h15, 1'b0, 1'b1, 8'h10});
		check("sub_w", w_wdata_o, 8'h01);
		check("flags2", alu_flags_o, 5'h03);
		check("sub_wwe", w_we_o, 1'b1);
		run(16'h0003);
		check("pd", power_down_flag_o, 1'b0);
		check("to", time_out_flag_o, 1'b1);
		check("osc", osc_run_o, 1'b0);
		check("phase_sleep", phase_o, 2'h0);
		run({7'h34, 1'b0, 8'h20});
		check("asleep_we", file_we_o, 1'b0);
		wdt_timeout_i = 1'b1;
		wake();
		check("wdt_osc", osc_run_o, 1'b1);
		check("wdt_to", time_out_flag_o, 1'b0);
		wdt_timeout_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		run(16'h0003);
		check("to_set", time_out_flag_o, 1'b1);
		ext_wake_i = 1'b1;
		wake();
		check("ext_osc", osc_run_o, 1'b1);
		check("ext_to", time_out_flag_o, 1'b1);
		stop_test();
	end
endmodule // tb_ssx_exec
